// >>> rtl/mcr45_regs.v
// APB register bank for configuration registers four and five with lock and pin control
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// - Temperature format bit 1 selects twos complement, 0 selects offset-64 codes.
// - Changing the format reinterprets every temperature value under the new encoding.
// - Drive frequency bit 0 picks high-frequency, 1 picks low-frequency fan drive.
// - With general-purpose function on, direction bit 0 means input, 1 output.
// - As an output, polarity bit 0 means active low, 1 active high.
// - With the lock bit set, writes to both configuration registers are ignored.
// - Pin select field chooses fan speed, thermal, alert or general-purpose function.
// - Threshold field sets 20/40/80/130 mV two-wire sensing, low-frequency mode only.
// - Each bypass bit rescales its voltage channel to 0 V through 2.2965 V.
// - Both test registers read as reserved bits and ignore writes.
module mcr45_regs
#(
	parameter TEMP_WIDTH = 8
)
(
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Temperature path
	input wire [TEMP_WIDTH-1:0] temp_native,
	output reg [TEMP_WIDTH-1:0] temp_shown,
	// Fan drive and measurement controls
	output reg drive_freq_sel,
	output reg [1:0] tach_input_threshold,
	output reg tach_threshold_active,
	output reg bypass_atten_low_rail,
	output reg bypass_atten_core_rail,
	output reg bypass_atten_mid_rail,
	output reg bypass_atten_high_rail,
	// Shared pin functions
	output reg [1:0] shared_pin_function,
	output reg fan_four_speed_en,
	output reg thermal_alarm_en,
	output reg alert_en,
	// General-purpose pin: four signals, enable low while driving
	input wire gp_pin_in,
	output reg gp_pin_out,
	output reg gp_pin_oe_n,
	output reg gp_pin_level,
	// Lock state
	output reg config_locked
);

`include "mcr45_consts.vh"

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	reg [3:0] config_five_reg;
	reg [7:0] config_four_reg;
	reg lock_reg;
	reg gp_out_value_reg;
	reg [3:0] config_five_next;
	reg [7:0] config_four_next;
	reg lock_next;

	wire [9:0] reg_index;
	wire setup_phase;
	wire wr_access;
	wire rd_access;
	wire addr_known;
	wire [TEMP_WIDTH-1:0] conv_code;
	wire [7:0] five_wdata;

	assign reg_index = paddr[11:2];
	assign setup_phase = psel & ~penable;
	// Unused upper bits of configuration five are dropped before they reach storage
	assign five_wdata = pwdata[7:0] & `MCR45_F5_USED_MASK;
	assign addr_known = (reg_index == {2'h0, `MCR45_IDX_CONFIG_FIVE}) |
		(reg_index == {2'h0, `MCR45_IDX_CONFIG_FOUR}) |
		(reg_index == {2'h0, `MCR45_IDX_TEST_ONE}) |
		(reg_index == {2'h0, `MCR45_IDX_TEST_TWO}) |
		(reg_index == {2'h0, `MCR45_IDX_LOCK_CTRL});
	// Writes land on the access-phase edge; the slave always answers in one wait-free access
	assign wr_access = psel & penable & pwrite & pready;
	assign rd_access = psel & penable & ~pwrite & pready;

	////////////////////////////////////////////////////////////////////////////////
	// Write decode
	always @*
	begin
		config_five_next = config_five_reg;
		config_four_next = config_four_reg;
		lock_next = lock_reg;
		if (wr_access && pstrb[0])
		begin
			// Lock is sticky until reset so a runaway driver cannot reopen it
			if (reg_index == {2'h0, `MCR45_IDX_LOCK_CTRL})
				lock_next = lock_reg | pwdata[0];
			if (!lock_reg)
			begin
				if (reg_index == {2'h0, `MCR45_IDX_CONFIG_FIVE})
					config_five_next = five_wdata[3:0];
				if (reg_index == {2'h0, `MCR45_IDX_CONFIG_FOUR})
					config_four_next = pwdata[7:0];
			end
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			config_five_reg <= 4'h0;
			config_four_reg <= `MCR45_RST_CONFIG_FOUR;
			lock_reg <= 1'b0;
		end
		else
		begin
			config_five_reg <= config_five_next;
			config_four_reg <= config_four_next;
			lock_reg <= lock_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: pready high one cycle after setup, errors on unmapped indices
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= setup_phase;
			pslverr <= setup_phase & ~addr_known;
			if (setup_phase && !pwrite)
			begin
				case (reg_index)
					{2'h0, `MCR45_IDX_CONFIG_FIVE}: prdata <= {28'h0000000, config_five_reg};
					{2'h0, `MCR45_IDX_CONFIG_FOUR}: prdata <= {24'h000000, config_four_reg};
					{2'h0, `MCR45_IDX_TEST_ONE}: prdata <= {24'h000000, `MCR45_RST_TEST_ONE};
					{2'h0, `MCR45_IDX_TEST_TWO}: prdata <= {24'h000000, `MCR45_RST_TEST_TWO};
					{2'h0, `MCR45_IDX_LOCK_CTRL}: prdata <= {31'h00000000, lock_reg};
					default: prdata <= 32'h00000000;
				endcase
			end
			else if (rd_access)
				prdata <= prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Temperature format: conversion is combinational on every value, so a format
	// change takes effect on all temperatures at once with no stored copies to refresh
	mcr45_temp_conv
	#(
		.WIDTH(TEMP_WIDTH)
	)
	u_temp_conv
	(
		.offset_mode(~config_five_reg[`MCR45_F5_TEMP_FMT]),
		.native_code(temp_native),
		.shown_code(conv_code)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			temp_shown <= {TEMP_WIDTH{1'b0}};
		else
			temp_shown <= conv_code;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration outputs
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drive_freq_sel <= 1'b0;
			tach_input_threshold <= 2'h0;
			tach_threshold_active <= 1'b0;
			bypass_atten_low_rail <= 1'b0;
			bypass_atten_core_rail <= 1'b0;
			bypass_atten_mid_rail <= 1'b0;
			bypass_atten_high_rail <= 1'b0;
			shared_pin_function <= `MCR45_PF_FAN_SPEED;
			fan_four_speed_en <= 1'b1;
			thermal_alarm_en <= 1'b0;
			alert_en <= 1'b0;
			config_locked <= 1'b0;
		end
		else
		begin
			drive_freq_sel <= config_five_reg[`MCR45_F5_DRIVE_FREQ];
			tach_input_threshold <= config_four_reg[`MCR45_F4_THRESH_LSB +: 2];
			// Threshold only matters in low-frequency drive mode
			tach_threshold_active <= config_five_reg[`MCR45_F5_DRIVE_FREQ];
			bypass_atten_low_rail <= config_four_reg[`MCR45_F4_BYPASS_LSB];
			bypass_atten_core_rail <= config_four_reg[`MCR45_F4_BYPASS_LSB + 1];
			bypass_atten_mid_rail <= config_four_reg[`MCR45_F4_BYPASS_LSB + 2];
			bypass_atten_high_rail <= config_four_reg[`MCR45_F4_BYPASS_LSB + 3];
			shared_pin_function <= config_four_reg[`MCR45_F4_PIN_FUNC_LSB +: 2];
			fan_four_speed_en <= config_four_reg[1:0] == `MCR45_PF_FAN_SPEED;
			thermal_alarm_en <= config_four_reg[1:0] == `MCR45_PF_THERMAL;
			alert_en <= config_four_reg[1:0] == `MCR45_PF_ALERT;
			config_locked <= lock_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// General-purpose pin
	wire gp_enabled;
	wire gp_is_output;
	assign gp_enabled = config_four_reg[1:0] == `MCR45_PF_GP_PIN;
	assign gp_is_output = gp_enabled & config_five_reg[`MCR45_F5_GP_DIR];

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gp_out_value_reg <= 1'b0;
			gp_pin_out <= 1'b1;
			gp_pin_oe_n <= 1'b1;
			gp_pin_level <= 1'b0;
		end
		else
		begin
			// Logical assert level; held by the own lock control bit 1 of the lock register
			if (wr_access && pstrb[0] && reg_index == {2'h0, `MCR45_IDX_LOCK_CTRL})
				gp_out_value_reg <= pwdata[1];
			// Active low drives the inverse of the asserted level
			gp_pin_out <= config_five_reg[`MCR45_F5_GP_POL] ? gp_out_value_reg : ~gp_out_value_reg;
			gp_pin_oe_n <= ~gp_is_output;
			// Input sample is the pin level seen as an input, or the driven level
			gp_pin_level <= gp_is_output ? gp_pin_out : gp_pin_in;
		end
	end

endmodule

// >>> rtl/mcr45_consts.vh
// Offsets, field positions and reset values of the monitor configuration registers
`ifndef MCR45_CONSTS_VH
`define MCR45_CONSTS_VH

// Printed offsets step by one, not by four: they are register indices
`define MCR45_IDX_CONFIG_FIVE 8'h7C
`define MCR45_IDX_CONFIG_FOUR 8'h7D
`define MCR45_IDX_TEST_ONE 8'h7E
`define MCR45_IDX_TEST_TWO 8'h7F
// Own control register holding the global lock bit
`define MCR45_IDX_LOCK_CTRL 8'h80

// Reset values
`define MCR45_RST_CONFIG_FIVE 8'h00
`define MCR45_RST_CONFIG_FOUR 8'h00
`define MCR45_RST_TEST_ONE 8'h00
`define MCR45_RST_TEST_TWO 8'h00

// Configuration five fields
`define MCR45_F5_TEMP_FMT 0
`define MCR45_F5_DRIVE_FREQ 1
`define MCR45_F5_GP_DIR 2
`define MCR45_F5_GP_POL 3
`define MCR45_F5_USED_MASK 8'h0F

// Configuration four fields
`define MCR45_F4_PIN_FUNC_LSB 0
`define MCR45_F4_THRESH_LSB 2
`define MCR45_F4_BYPASS_LSB 4

// Shared pin function codes
`define MCR45_PF_FAN_SPEED 2'h0
`define MCR45_PF_THERMAL 2'h1
`define MCR45_PF_ALERT 2'h2
`define MCR45_PF_GP_PIN 2'h3

// Offset-64 bias of the temperature encoding
`define MCR45_TEMP_OFFSET 8'h40

`endif

// >>> rtl/mcr45_temp_conv.v
// Temperature code converter between stored twos complement and the software-visible format
`timescale 1ns/10ps

module mcr45_temp_conv
#(
	parameter WIDTH = 8
)
(
	// Control
	input wire offset_mode,
	// Data
	input wire [WIDTH-1:0] native_code,
	output wire [WIDTH-1:0] shown_code
);

`include "mcr45_consts.vh"

	// Offset-64 adds the bias; wraps modulo 2^WIDTH like the hardware code space
	assign shown_code = offset_mode ? native_code + `MCR45_TEMP_OFFSET : native_code;

endmodule

// >>> tb/mcr45_props.sv
// Port-level assertions for the configuration register bank
`timescale 1ns/10ps
module mcr45_props
(
	// Clock, reset and bus
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Controls
	input wire [7:0] temp_native,
	input wire [7:0] temp_shown,
	input wire drive_freq_sel,
	input wire tach_threshold_active,
	input wire [1:0] shared_pin_function,
	input wire fan_four_speed_en,
	input wire thermal_alarm_en,
	input wire alert_en,
	input wire gp_pin_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_fmt; $past(presetn) |-> temp_shown == $past(temp_native) || temp_shown == $past(temp_native) + 8'h40; endproperty
	a_fmt: assert property (p_fmt) else $error("temp code not native or offset");
	property p_thr; tach_threshold_active == drive_freq_sel; endproperty
	a_thr: assert property (p_thr) else $error("threshold gate differs from drive mode");
	property p_fan; fan_four_speed_en == (shared_pin_function == 2'h0); endproperty
	a_fan: assert property (p_fan) else $error("fan input enable wrong");
	property p_alm; thermal_alarm_en == (shared_pin_function == 2'h1) && alert_en == (shared_pin_function == 2'h2);
	endproperty
	a_alm: assert property (p_alm) else $error("thermal or alert enable wrong");
	property p_oe; !gp_pin_oe_n |-> shared_pin_function == 2'h3; endproperty
	a_oe: assert property (p_oe) else $error("pin driven outside gp function");
	property p_rdy; pready |-> psel && penable ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready outside access or too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_up; pready && !pwrite && paddr == 12'h1F0 |-> prdata[31:4] == 28'h0; endproperty
	a_up: assert property (p_up) else $error("unused bits read nonzero");
	property p_tst; pready && !pwrite && paddr[11:3] == 9'h3F |-> prdata == 32'h0; endproperty
	a_tst: assert property (p_tst) else $error("test register read nonzero");
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
	reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gp_pin_in = 0;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0;
	reg [7:0] temp_native = 8'h0;
	wire [31:0] prdata;
	wire pready, pslverr, dfs, tta, blo, bco, bmi, bhi, ffs, tae, ale, gpo, gpoe_n, gpl, locked;
	wire [1:0] thr, spf;
	wire [7:0] tshow;
	int n_mismatch = 0, num_checks = 0, cyc = 0, i;
	reg [7:0] c5 = 8'h0, c4 = 8'h0;
	reg lk = 0, err;
	reg [31:0] rd;
	mcr45_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.temp_native(temp_native), .temp_shown(tshow), .drive_freq_sel(dfs), .tach_input_threshold(thr),
		.tach_threshold_active(tta), .bypass_atten_low_rail(blo), .bypass_atten_core_rail(bco),
		.bypass_atten_mid_rail(bmi), .bypass_atten_high_rail(bhi), .shared_pin_function(spf),
		.fan_four_speed_en(ffs), .thermal_alarm_en(tae), .alert_en(ale), .gp_pin_in(gp_pin_in),
		.gp_pin_out(gpo), .gp_pin_oe_n(gpoe_n), .gp_pin_level(gpl), .config_locked(locked));
	always #2.5 pclk = ~pclk;
	function automatic [7:0] exp_temp(input fmt, input [7:0] n);
		exp_temp = fmt ? n : n + 8'h40;
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Master holds the request until ready is sampled high
	task automatic apb(input w, input [11:0] a, input [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input [7:0] v5, input [7:0] v4);
		apb(1, 12'h1F0, {24'h0, v5});
		apb(1, 12'h1F4, {24'h0, v4});
		if (!lk)
		begin
			c5 = v5 & 8'h0F;
			c4 = v4;
		end
		temp_native <= $urandom;
		repeat (3) @(posedge pclk);
		`CHK("freq", c5[1], dfs)
		`CHK("thresh", c4[3:2], thr)
		`CHK("bypass", c4[7:4], {bhi, bmi, bco, blo})
		`CHK("pinfunc", c4[1:0], spf)
		`CHK("oe_n", !(c4[1:0] == 2'h3 && c5[2]), gpoe_n)
		`CHK("temp", exp_temp(c5[0], temp_native), tshow)
		apb(0, 12'h1F0, 0);
		`CHK("cfg5", {24'h0, c5}, rd)
		apb(0, 12'h1F4, 0);
		`CHK("cfg4", {24'h0, c4}, rd)
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			report_and_stop;
		end
	end
	initial
	begin
		$urandom(32'hB752);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			apb(0, 12'h1F0 + 12'(4 * i), 0);
			`CHK("reset value", 32'h0, rd)
		end
		`CHK("fan default", 1'b1, ffs)
		$display("test reset done");
		for (i = 0; i < 8; i++)
			cfg(8'(2 * i), {4'h5, 2'(i), 2'(i)});
		cfg(8'hFF, 8'hFF);
		repeat (12) cfg($urandom, $urandom);
		$display("test fields done");
		apb(1, 12'h1F8, 32'hFF);
		apb(1, 12'h1FC, 32'hAA);
		apb(0, 12'h1FC, 0);
		`CHK("test reg", 32'h0, rd)
		apb(1, 12'h204, 32'h1);
		`CHK("unmapped", 1'b1, err)
		$display("test reserved done");
		apb(1, 12'h200, 32'h1);
		lk = 1;
		repeat (4) cfg($urandom, $urandom);
		`CHK("locked", 1'b1, locked)
		apb(0, 12'h200, 0);
		`CHK("lock read", 32'h1, rd)
		apb(1, 12'h200, 32'h3);
		repeat (3) @(posedge pclk);
		`CHK("gp out", c5[3], gpo)
		`CHK("gp level", (c4[1:0] == 2'h3 && c5[2]) ? c5[3] : gp_pin_in, gpl)
		$display("test lock done");
		report_and_stop;
	end
endmodule
bind mcr45_regs mcr45_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.temp_native(temp_native), .temp_shown(temp_shown), .drive_freq_sel(drive_freq_sel),
	.tach_threshold_active(tach_threshold_active), .shared_pin_function(shared_pin_function),
	.fan_four_speed_en(fan_four_speed_en), .thermal_alarm_en(thermal_alarm_en), .alert_en(alert_en),
	.gp_pin_oe_n(gp_pin_oe_n));
